// [hw/fault_supervisor.sv]
// fault supervisor for a boost led driver: gates boost, disconnect and sinks
// assumes comparator inputs and host pins are asynchronous, clock is 20 mhz
`timescale 1ns/100ps
module fault_supervisor
   import fault_sup_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // analog comparator outputs, detection done and switching clock
   input wire comp_t i_comp,
   input wire logic [STRINGS-1:0] i_string_reg,
   input wire logic i_detect_done,
   input wire logic i_sw_cycle,
   // host pins
   input wire logic i_enable_pin,
   input wire logic i_freq_set_sync_pin,
   // power stage controls and host flags
   output drive_t o_drive,
   output logic [STRINGS-1:0] o_sink_en,
   output logic o_fault_b,
   output logic o_low_power
);
   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   comp_t comp;
   logic [STRINGS-1:0] str_reg;
   logic en_pin;
   logic sync_pin;
   logic det_done;
   logic sw_cyc;
   logic sync_low;
   logic en_low_done;
   logic uv_fall_done;
   // one wide synchroniser keeps every input aligned to the same edge;
   // the price is a lag of four to five cycles on every comparator
   sync3 #(
      .W($bits(comp_t) + STRINGS + 4)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_comp, i_string_reg, i_enable_pin, i_freq_set_sync_pin,
                i_detect_done, i_sw_cycle}),
      .o_sync({comp, str_reg, en_pin, sync_pin, det_done, sw_cyc})
   );
   // ----------------------------------------
   // long-low and glitch filters
   // ----------------------------------------
   // the sync pin reads low for a few cycles after reset while the
   // synchroniser fills; that is far shorter than the long-low limit
   low_timer #(
      .LIMIT(CNT_W'(SYNC_LOW_CYC))
   ) u_sync_low (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_level(!sync_pin),
      .o_done(sync_low)
   );
   low_timer #(
      .LIMIT(CNT_W'(EN_LOW_CYC))
   ) u_en_low (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_level(!en_pin),
      .o_done(en_low_done)
   );
   low_timer #(
      .LIMIT(CNT_W'(UV_FALL_CYC))
   ) u_uv_fall (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_level(comp.uv_fall),
      .o_done(uv_fall_done)
   );
   // ----------------------------------------
   // state and latched faults
   // ----------------------------------------
   state_t state;
   state_t next_state;
   logic supply_ok;
   logic uv_shut;
   logic hard_fault;
   logic latched;
   logic oc1x_act;
   logic oc1x_exp;
   logic [CNT_W-1:0] oc1x_cnt;
   logic [STRINGS-1:0] string_off;
   logic sw_cyc_d;
   // a level on the supply comparators; both must agree to power up
   assign supply_ok = comp.uv_rise_ok && comp.sense_ok;
   assign uv_shut = uv_fall_done || comp.vin_low;
   // latching sources; 2x path uses synchronised level, well inside 3 us
   assign hard_fault = comp.sw_ovp || comp.ilim2 || comp.oc2x || oc1x_exp;
   // fault memory: set wins, cleared only by full shutdown
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         latched <= 1'b0;
      end else if (hard_fault && state != ST_SHUT) begin
         latched <= 1'b1;
      end else if (en_low_done || uv_shut) begin
         latched <= 1'b0;
      end
   end
   // state sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_SHUT: begin
            if (en_pin && supply_ok && !latched) begin
               next_state = ST_DETECT;
            end
         end
         ST_DETECT: begin
            if (det_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (hard_fault) begin
               next_state = ST_LATCH;
            end
         end
         ST_LATCH: begin
            next_state = ST_LATCH;
         end
         default: begin
            next_state = ST_SHUT;
         end
      endcase
      if (en_low_done || uv_shut || sync_low) begin
         next_state = ST_SHUT;
      end else if (hard_fault && state != ST_SHUT) begin
         next_state = ST_LATCH;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state <= ST_SHUT;
      end else begin
         state <= next_state;
      end
   end
   // ----------------------------------------
   // 1x overcurrent window, counted in switching cycles
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sw_cyc_d <= 1'b0;
      end else begin
         sw_cyc_d <= sw_cyc;
      end
   end
   // counts rising edges of the switching clock, not system clocks,
   // so the window follows the real switching frequency
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || !comp.oc1x || state != ST_RUN) begin
         oc1x_cnt <= '0;
         oc1x_act <= 1'b0;
         oc1x_exp <= 1'b0;
      end else begin
         oc1x_act <= 1'b1;
         if (sw_cyc && !sw_cyc_d && oc1x_cnt != CNT_W'(OC1X_BOUND)) begin
            oc1x_cnt <= oc1x_cnt + 16'h0001;
         end
         oc1x_exp <= (oc1x_cnt == CNT_W'(OC1X_BOUND));
      end
   end
   // ----------------------------------------
   // open string removal after overvoltage
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || state == ST_SHUT) begin
         string_off <= '0;
      end else if (comp.ovp_trip && state == ST_RUN) begin
         string_off <= string_off | ~str_reg;
      end
   end
   // ----------------------------------------
   // outputs, all registered
   // ----------------------------------------
   // outputs other than cycle_kill follow next_state so a fault turns them off one edge sooner
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_drive <= '0;
         o_sink_en <= '0;
      end else begin
         // boost resumes by itself once overvoltage clears
         o_drive.boost_en <= (next_state == ST_RUN) && !comp.ovp_trip;
         o_drive.cycle_kill <= comp.ilim;
         o_drive.disc_on <= (next_state == ST_RUN) || (next_state == ST_DETECT);
         o_drive.sinks_on <= (next_state == ST_RUN);
         o_sink_en <= (next_state == ST_RUN) ? ~string_off : '0;
      end
   end
   // active-low flag: latched fault or live 1x condition
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_fault_b <= 1'b1;
      end else begin
         o_fault_b <= !(latched || next_state == ST_LATCH ||
                        (comp.oc1x && state == ST_RUN));
      end
   end
   // low-power flag: set by enable long-low, dropped when enable returns
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_low_power <= 1'b0;
      end else if (en_low_done) begin
         o_low_power <= 1'b1;
      end else if (en_pin) begin
         o_low_power <= 1'b0;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_oc1x_gone;
      !comp.oc1x ##1 1'b1;
   endsequence
   chk_ovp_stops_boost: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      comp.ovp_trip |=> !o_drive.boost_en)
      else $error("boost running during overvoltage");
   chk_latch_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state == ST_LATCH && !en_low_done && !uv_shut && !sync_low) |=> state == ST_LATCH)
      else $error("latched state left early");
   chk_ilim2_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (comp.ilim2 && state == ST_RUN) |=> !o_drive.disc_on && !o_drive.sinks_on)
      else $error("secondary overcurrent did not shut down");
   chk_fault_flag_1x: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (comp.oc1x && state == ST_RUN) |=> !o_fault_b)
      else $error("fault flag missing in 1x mode");
   chk_1x_recover: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state == ST_RUN && !latched) ##0 s_oc1x_gone |-> o_fault_b || latched)
      else $error("fault flag stuck after 1x cleared");
   chk_sync_shut: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      sync_low |=> state == ST_SHUT && !o_drive.disc_on)
      else $error("sync long-low did not shut down");
   chk_en_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (en_low_done && !hard_fault) |=> !latched)
      else $error("long-low did not clear faults");
   chk_oc2x_time: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(comp.oc2x) && state == ST_RUN ##1 comp.oc2x [*4] |-> ##[0:40] !o_drive.sinks_on)
      else $error("2x shutdown too slow");
   chk_supply_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state == ST_SHUT && !supply_ok) |=> state == ST_SHUT)
      else $error("enabled without supply ok");
   // ----------------------------------------
   // checks on strings, restart, filters and latching
   // ----------------------------------------
   // an overvoltage seen in run that leaves the block running
   sequence s_ovp_in_run;
      comp.ovp_trip && state == ST_RUN ##1 next_state == ST_RUN;
   endsequence
   // a 1x window that ran out while the block may still latch
   sequence s_1x_expired;
      oc1x_exp && state != ST_SHUT && !en_low_done && !uv_shut && !sync_low;
   endsequence
   // strings out of regulation at the trip lose their sink
   chk_open_string_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      s_ovp_in_run
      |=> (o_sink_en & ~$past(str_reg, 2)) == '0)
      else $error("open string still sinking");
   // no overvoltage and still running: boost must be back on
   chk_boost_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state == ST_RUN && next_state == ST_RUN && !comp.ovp_trip)
      |=> o_drive.boost_en)
      else $error("boost did not resume");
   // a supply shutdown is a full shutdown and wipes the fault memory
   chk_uv_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (uv_shut && !hard_fault)
      |=> !latched)
      else $error("supply shutdown kept latched fault");
   // run is only reached through detection with detection finished
   chk_detect_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(state == ST_RUN)
      |-> $past(state == ST_DETECT) && $past(det_done))
      else $error("run entered without detection");
   // a current-limit trip cuts one cycle and leaves the boost enabled
   chk_cycle_kill: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (comp.ilim && state == ST_RUN && next_state == ST_RUN && !comp.ovp_trip)
      |=> o_drive.cycle_kill && o_drive.boost_en)
      else $error("current limit handled wrongly");
   // the window counter only runs in 1x mode and never passes its bound
   chk_1x_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      oc1x_cnt != '0
      |-> oc1x_act && oc1x_cnt <= CNT_W'(OC1X_BOUND))
      else $error("1x counter out of range");
   // the enable long-low lands in shutdown with the low-power flag up
   chk_low_power: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      en_low_done
      |=> o_low_power && state == ST_SHUT)
      else $error("long-low did not enter low power");
   // any latched fault shows on the flag on the next edge
   chk_latch_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      latched
      |=> !o_fault_b)
      else $error("latched fault not flagged");
   // a supply dip that ends resets the filter, so no shutdown follows
   chk_uv_glitch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !comp.uv_fall
      |=> !uv_fall_done)
      else $error("supply glitch not filtered");
   // a low supply forces shutdown on the next edge
   chk_vin_low_shut: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      comp.vin_low
      |=> state == ST_SHUT && !o_drive.sinks_on)
      else $error("low supply did not shut down");
   // in shutdown with enable low every sink stays off
   chk_shut_sinks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state == ST_SHUT && !en_pin)
      |=> !o_drive.sinks_on && o_sink_en == '0)
      else $error("sinks on during shutdown");
   // an expired 1x window latches the block
   chk_1x_expire: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      s_1x_expired
      |=> state == ST_LATCH && latched)
      else $error("1x expiry did not latch");
endmodule

// [hw/fault_sup_pkg.sv]
// shared constants and carrier types for the led driver fault supervisor
// assumes a single 20 mhz system clock; no software-visible registers
package fault_sup_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int SYNC_LOW_NS = 7000;            // long-low on sync pin
   localparam int SYNC_LOW_CYC = (SYNC_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int UV_FALL_NS = 50000;            // falling undervoltage_lockout filter
   localparam int UV_FALL_CYC = (UV_FALL_NS * CLK_MHZ + 999) / 1000;
   localparam int OC2X_NS = 3000;                // 2x shutdown bound
   localparam int OC2X_CYC = (OC2X_NS * CLK_MHZ) / 1000;
   localparam int OC1X_BOUND = 10000;            // switching cycles in 1x mode
   localparam int EN_LOW_CYC = 32750;            // enable long-low count
   localparam int CNT_W = 16;
   localparam int SYNC_W = 3;
   localparam int STRINGS = 4;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic ovp_trip;      // primary overvoltage comparator, high = trip
      logic sw_ovp;        // switch node overvoltage detector
      logic ilim;          // cycle-by-cycle current limit comparator
      logic ilim2;         // secondary switch overcurrent comparator
      logic oc1x;          // input current above 1x limit
      logic oc2x;          // input current above 2x limit
      logic uv_rise_ok;    // supply above rising threshold
      logic sense_ok;      // sense pin above rising threshold
      logic uv_fall;       // supply below falling threshold
      logic vin_low;       // supply below 4.35 v
   } comp_t;
   typedef struct packed {
      logic boost_en;
      logic cycle_kill;
      logic disc_on;
      logic sinks_on;
   } drive_t;
   typedef enum logic [2:0] {
      ST_SHUT = 3'b000,
      ST_DETECT = 3'b001,
      ST_RUN = 3'b010,
      ST_LATCH = 3'b011
   } state_t;
endpackage

// [hw/sync3.sv]
// three-flop synchroniser with agreement of the last two stages
// assumes the input is asynchronous to i_clk
`timescale 1ns/100ps
module sync3
   import fault_sup_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   // ----------------------------------------
   // stages; first flop feeds only the second
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // output changes only where stages two and three agree
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_sync <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               o_sync[i] <= s3[i];
            end
         end
      end
   end
endmodule

// [hw/low_timer.sv]
// counts consecutive cycles of a level and flags when a limit is passed
// assumes a synchronised input
`timescale 1ns/100ps
module low_timer
   import fault_sup_pkg::*;
#(
   parameter logic [CNT_W-1:0] LIMIT = 16'h0001
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // level and result
   input wire logic i_level,
   output logic o_done
);
   logic [CNT_W-1:0] cnt;
   // saturating run counter, cleared when the level drops
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || !i_level) begin
         cnt <= '0;
      end else if (cnt != LIMIT) begin
         cnt <= cnt + 16'h0001;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_done <= 1'b0;
      end else begin
         o_done <= i_level && (cnt == LIMIT);
      end
   end
endmodule

// [verification/host_model.sv]
// host controller model: drives the enable/dimming pin and the sync pin
// assumes the bench commands levels through the tasks; enable idles low, sync idles high
`timescale 1ns/100ps
module host_model (
   // clock
   input wire logic i_clk,
   // host pins
   output logic o_enable_pin,
   output logic o_freq_set_sync_pin
);
   // start disabled; the sync pin rests high so no shutdown is requested
   initial begin
      o_enable_pin = 1'b0;
      o_freq_set_sync_pin = 1'b1;
   end
   // levels change just after an edge, as a clocked host would
   task automatic set_enable(input logic lvl);
      @(posedge i_clk);
      o_enable_pin <= lvl;
   endtask
   task automatic set_sync(input logic lvl);
      @(posedge i_clk);
      o_freq_set_sync_pin <= lvl;
   endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the fault supervisor with a behavioural model
// assumes the design sees inputs about 5 cycles late, so checks wait 12+
`timescale 1ns/100ps
module testbench;
   import fault_sup_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   comp_t comp = '0;
   logic [STRINGS-1:0] str_reg = 4'hf;
   logic det_done = 1'b0;
   logic sw_cyc = 1'b0;
   logic en_pin;
   logic sync_pin;
   drive_t drive;
   logic [STRINGS-1:0] sink_en;
   logic fault_b;
   logic low_power;
   int error_cnt = 0;
   int cmp_count = 0;
   bit m_run, m_on, m_ovp, m_ilim, m_flt, m_lp;
   logic [STRINGS-1:0] m_mask = 4'hf;
   logic [STRINGS-1:0] rnd;
   always #25 i_clk = ~i_clk;
   fault_supervisor fault_supervisor_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_comp(comp),
      .i_string_reg(str_reg), .i_detect_done(det_done), .i_sw_cycle(sw_cyc),
      .i_enable_pin(en_pin), .i_freq_set_sync_pin(sync_pin), .o_drive(drive),
      .o_sink_en(sink_en), .o_fault_b(fault_b), .o_low_power(low_power));
   host_model host_model_i (.i_clk(i_clk), .o_enable_pin(en_pin),
      .o_freq_set_sync_pin(sync_pin));
   //----------------------------------------
   // compare and report
   //----------------------------------------
   task automatic stop_test();
      $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp, input string s);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string s);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %b exp %b", $time, s, got, exp);
      end
   endtask
   // model outputs: boost is held off by overvoltage, sinks follow the string mask
   task automatic check();
      drive_t ed;
      ed = '{m_run & ~m_ovp, m_run & m_ilim, m_on, m_run};
      cmp_vec({drive, sink_en}, {ed, m_run ? m_mask : 4'h0}, "drive and sinks");
      cmp_bit(fault_b, ~m_flt, "fault flag");
      cmp_bit(low_power, m_lp, "low power");
   endtask
   // any shutdown restores strings removed after an open-string event
   task automatic mdl(input bit run, input bit on, input bit flt);
      m_run = run;
      m_on = on;
      m_flt = flt;
      if (!on) m_mask = 4'hf;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic end_test(input string s);
      $display("done: %s", s);
   endtask
   // latched fault on field k, cleared here by a falling-supply shutdown
   task automatic latch_then_uv(input int k);
      @(posedge i_clk);
      if (k == 0) comp.sw_ovp <= 1'b1;
      else comp.oc2x <= 1'b1;
      settle(k == 0 ? 12 : OC2X_CYC);
      mdl(0, 0, 1);
      check();
      comp.sw_ovp <= 1'b0;
      comp.oc2x <= 1'b0;
      settle(12);
      check();
      comp.uv_fall <= 1'b1;
      settle(UV_FALL_CYC + 20);
      comp.uv_fall <= 1'b0;
      settle(20);
      mdl(1, 1, 0);
      check();
   endtask
   //----------------------------------------
   // sequence
   //----------------------------------------
   initial begin
      rnd = 4'($urandom(66));
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      settle(2);
      check();
      comp.uv_rise_ok <= 1'b1;
      host_model_i.set_enable(1'b1);
      settle(12);
      check();
      comp.sense_ok <= 1'b1;
      settle(12);
      mdl(0, 1, 0);
      check();
      det_done <= 1'b1;
      settle(12);
      mdl(1, 1, 0);
      check();
      end_test("power up");
      rnd = 4'h1 + 4'($urandom % 14);
      str_reg <= rnd;
      settle(8);
      comp.ovp_trip <= 1'b1;
      settle(12);
      m_ovp = 1;
      m_mask = rnd;
      check();
      comp.ovp_trip <= 1'b0;
      str_reg <= 4'hf;
      settle(12);
      m_ovp = 0;
      check();
      comp.ilim <= 1'b1;
      settle(12);
      m_ilim = 1;
      check();
      comp.ilim <= 1'b0;
      settle(12);
      m_ilim = 0;
      check();
      end_test("overvoltage and limit");
      comp.oc1x <= 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(posedge i_clk);
         sw_cyc <= ($urandom % 4 == 0) ? ~sw_cyc : sw_cyc;
      end
      settle(1);
      m_flt = 1;
      check();
      comp.oc1x <= 1'b0;
      settle(12);
      m_flt = 0;
      check();
      end_test("1x overcurrent");
      host_model_i.set_sync(1'b0);
      settle(SYNC_LOW_CYC - 10);
      check();
      settle(22);
      mdl(0, 0, 0);
      check();
      host_model_i.set_sync(1'b1);
      settle(20);
      mdl(1, 1, 0);
      check();
      comp.uv_fall <= 1'b1;
      settle(UV_FALL_CYC - 20);
      check();
      settle(40);
      mdl(0, 0, 0);
      check();
      comp.uv_fall <= 1'b0;
      settle(20);
      mdl(1, 1, 0);
      check();
      comp.vin_low <= 1'b1;
      settle(12);
      mdl(0, 0, 0);
      check();
      comp.vin_low <= 1'b0;
      settle(20);
      mdl(1, 1, 0);
      check();
      end_test("host and supply shutdown");
      for (int k = 0; k < 2; k++) latch_then_uv(k);
      end_test("latched faults");
      comp.ilim2 <= 1'b1;
      settle(12);
      mdl(0, 0, 1);
      check();
      comp.ilim2 <= 1'b0;
      host_model_i.set_enable(1'b0);
      settle(1000);
      check();
      settle(EN_LOW_CYC);
      m_lp = 1;
      m_flt = 0;
      check();
      host_model_i.set_enable(1'b1);
      settle(20);
      m_lp = 0;
      mdl(1, 1, 0);
      check();
      end_test("enable long-low");
      // long 1x condition; each level holds two cycles so the synchroniser sees it
      comp.oc1x <= 1'b1;
      m_flt = 1;
      repeat (2 * OC1X_BOUND - 40) begin
         repeat (2) @(posedge i_clk);
         sw_cyc <= ~sw_cyc;
      end
      settle(1);
      check();
      repeat (80) begin
         repeat (2) @(posedge i_clk);
         sw_cyc <= ~sw_cyc;
      end
      settle(12);
      mdl(0, 0, 1);
      check();
      end_test("1x expiry");
      stop_test();
   end
   // watchdog: the sequence needs about 3.9 ms
   initial begin
      #4500000;
      error_cnt++;
      stop_test();
   end
endmodule
